// ### rtl/tccs_top.sv
// Count clock and edge selection for six timer channels with APB registers
`timescale 1ns/10ps

// What this block does
// - Edge code 00/01: internal falling/rising, external opposite
// - Edge high bit set: count both edges
// - Channel 0 prescale: /1,/4,/16, pins A-D
// - Channel 1: /1,/4,/16,A,B,/256, channel 2 wrap
// - Channel 2: /1,/4, pins A,B,C, /1024
// - Channel 3: 000 undivided, 100 pin A, others divided
// - Channel 4: /1,/4,/16,/64,A,C,/1024, channel 5 wrap
// - Channel 5: 000 undivided, pins A,C,D, others divided
// - Phase counting mode blocks prescale count enable
// - Edge choice ignored for undivided and cascade sources
module tccs_top
  import tccs_pkg::*;
#(
  parameter int unsigned CH0_PSC3_LOG2 = 6,
  parameter int unsigned CH1_PSC3_LOG2 = 6,
  parameter int unsigned CH2_PSC2_LOG2 = 4,
  parameter int unsigned CH2_PSC3_LOG2 = 6,
  parameter int unsigned CH3_PSC1_LOG2 = 2,
  parameter int unsigned CH3_PSC2_LOG2 = 4,
  parameter int unsigned CH3_PSC3_LOG2 = 6,
  parameter int unsigned CH3_PSC5_LOG2 = 8,
  parameter int unsigned CH3_PSC6_LOG2 = 10,
  parameter int unsigned CH3_PSC7_LOG2 = 10,
  parameter int unsigned CH5_PSC1_LOG2 = 2,
  parameter int unsigned CH5_PSC2_LOG2 = 4,
  parameter int unsigned CH5_PSC3_LOG2 = 6,
  parameter int unsigned CH5_PSC6_LOG2 = 10
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tccs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External count pins
  input wire logic ext_count_pin_a,
  input wire logic ext_count_pin_b,
  input wire logic ext_count_pin_c,
  input wire logic ext_count_pin_d,
  // Partner counter wrap pulses
  input wire logic channel2_counter_wrap,
  input wire logic channel5_counter_wrap,
  // Count enables per channel
  output logic [tccs_pkg::NUM_CH-1:0] count_en
);
  import tccs_pkg::*;

  localparam int unsigned ODD_LOG2 [14] = '{CH0_PSC3_LOG2, CH1_PSC3_LOG2, CH2_PSC2_LOG2,
    CH2_PSC3_LOG2, CH3_PSC1_LOG2, CH3_PSC2_LOG2, CH3_PSC3_LOG2, CH3_PSC5_LOG2,
    CH3_PSC6_LOG2, CH3_PSC7_LOG2, CH5_PSC1_LOG2, CH5_PSC2_LOG2, CH5_PSC3_LOG2,
    CH5_PSC6_LOG2};

  // Divided ratios must be /4 or slower and fit the prescaler
  for (genvar k = 0; k < 14; k++)
  begin : g_chk
    if (ODD_LOG2[k] < 2 || ODD_LOG2[k] > PRESC_W)
    begin : g_bad
      $error("Divider ratio outside /4 to /1024");
    end
  end

  logic [CTRL_W-1:0] ctrl_r [NUM_CH];
  logic [CTRL_W-1:0] ctrl_q_r [NUM_CH];
  logic [PRESC_W-1:0] presc_cnt_r;
  logic [NUM_PINS-1:0] pin_meta_r;
  logic [NUM_PINS-1:0] pin_sync_r;
  logic [NUM_PINS-1:0] pin_q_r;
  logic [NUM_PINS-1:0] pins_in;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [NUM_CH-1:0] cfg_stable;
  logic setup_cyc;
  logic wr_take;
  logic [5:0] reg_idx;
  logic ctrl_hit;

  assign pins_in = {ext_count_pin_d, ext_count_pin_c, ext_count_pin_b, ext_count_pin_a};

  // Source kind per channel and code
  function automatic tccs_src_e kind_f(input int ch, input logic [2:0] code);
    tccs_src_e k;
    k = SRC_DIV;
    if (code == 3'h0)
      k = SRC_UNDIV;
    else if ((ch == 1 || ch == 4) && code == 3'h7)
      k = SRC_CASC;
    else if (ch == 0)
      k = code[2] ? SRC_EXT : SRC_DIV;
    else if (ch == 1 || ch == 4)
      k = (code == 3'h4 || code == 3'h5) ? SRC_EXT : SRC_DIV;
    else if (ch == 2)
      k = (code[2] && code != 3'h7) ? SRC_EXT : SRC_DIV;
    else if (ch == 3)
      k = (code == 3'h4) ? SRC_EXT : SRC_DIV;
    else
      k = (code == 3'h4 || code == 3'h5 || code == 3'h7) ? SRC_EXT : SRC_DIV;
    return k;
  endfunction

  // Log2 of divide ratio per channel and code
  function automatic logic [3:0] div_f(input int ch, input logic [2:0] code);
    logic [3:0] d;
    d = DIV4_LOG2;
    case ({3'(ch), code})
      6'h01, 6'h09, 6'h11, 6'h21: d = DIV4_LOG2;
      6'h02, 6'h0a, 6'h22: d = DIV16_LOG2;
      6'h23: d = DIV64_LOG2;
      6'h0e: d = DIV256_LOG2;
      6'h17, 6'h26: d = DIV1024_LOG2;
      6'h03: d = 4'(CH0_PSC3_LOG2);
      6'h0b: d = 4'(CH1_PSC3_LOG2);
      6'h12: d = 4'(CH2_PSC2_LOG2);
      6'h13: d = 4'(CH2_PSC3_LOG2);
      6'h19: d = 4'(CH3_PSC1_LOG2);
      6'h1a: d = 4'(CH3_PSC2_LOG2);
      6'h1b: d = 4'(CH3_PSC3_LOG2);
      6'h1d: d = 4'(CH3_PSC5_LOG2);
      6'h1e: d = 4'(CH3_PSC6_LOG2);
      6'h1f: d = 4'(CH3_PSC7_LOG2);
      6'h29: d = 4'(CH5_PSC1_LOG2);
      6'h2a: d = 4'(CH5_PSC2_LOG2);
      6'h2b: d = 4'(CH5_PSC3_LOG2);
      6'h2e: d = 4'(CH5_PSC6_LOG2);
      default: d = DIV4_LOG2;
    endcase
    return d;
  endfunction

  // Pin picked by an external code; channels 4 and 5 skip pin B
  function automatic logic [1:0] pin_f(input int ch, input logic [2:0] code);
    logic [1:0] p;
    p = code[1:0];
    if (ch >= 4)
      p = (code == 3'h4) ? PIN_A : (code == 3'h5) ? PIN_C : PIN_D;
    return p;
  endfunction

  // Free-running prescaler; bit n-1 is a square wave at clk/2^n
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      presc_cnt_r <= '0;
    else
      presc_cnt_r <= presc_cnt_r + 10'h001;
  end

  // Two-flop pin synchroniser, plus one stage used only for checking
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
      pin_q_r <= '0;
    end
    else
    begin
      pin_meta_r <= pins_in;
      pin_sync_r <= pin_meta_r;
      pin_q_r <= pin_sync_r;
    end
  end

  // APB decode
  assign setup_cyc = psel & ~penable;
  assign wr_take = psel & penable & pready_r & pwrite;
  assign reg_idx = paddr[7:2];
  assign ctrl_hit = (paddr[1:0] == 2'h0) && (reg_idx < 6'(NUM_CH));

  // Ready one cycle after setup, so every access phase lasts one cycle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end
    else
    begin
      pready_r <= setup_cyc;
      pslverr_r <= setup_cyc && !ctrl_hit && paddr != STATUS_OFFSET;
      if (setup_cyc && !pwrite && ctrl_hit)
        prdata_r <= {26'h0, ctrl_r[reg_idx[2:0]]};
      else if (setup_cyc && !pwrite && paddr == STATUS_OFFSET)
        prdata_r <= {22'h0, pin_sync_r, count_en};
      else if (setup_cyc)
        prdata_r <= '0;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // Per-channel control registers and edge gates
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    tccs_src_e kind;
    logic level;
    logic casc;
    logic [3:0] dl;

    always_ff @(posedge clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        ctrl_r[i] <= CTRL_RESET;
        ctrl_q_r[i] <= CTRL_RESET;
      end
      else
      begin
        ctrl_q_r[i] <= ctrl_r[i];
        // Phase bit cannot be set on channels without phase counting
        if (wr_take && ctrl_hit && reg_idx == 6'(i))
          ctrl_r[i] <= pwdata[CTRL_W-1:0] & {PHASE_CAPABLE[i], 5'h1f};
      end
    end

    assign cfg_stable[i] = (ctrl_r[i] == ctrl_q_r[i]);

    // Phase counting takes the counter away from the prescaler
    always_comb
    begin
      dl = div_f(i, ctrl_r[i][PSC_MSB:PSC_LSB]);
      if (ctrl_r[i][PHASE_BIT])
        kind = SRC_OFF;
      else
        kind = kind_f(i, ctrl_r[i][PSC_MSB:PSC_LSB]);
      if (kind == SRC_EXT)
        level = pin_sync_r[pin_f(i, ctrl_r[i][PSC_MSB:PSC_LSB])];
      else if (kind == SRC_DIV)
        level = presc_cnt_r[dl - 4'h1];
      else
        level = 1'b0;
      casc = (i == 1) ? channel2_counter_wrap : (i == 4) ? channel5_counter_wrap : 1'b0;
    end

    tccs_edge_gate u_gate (
      .clk(clk),
      .reset_n(reset_n),
      .src_kind(kind),
      .src_level(level),
      .casc_pulse(casc),
      .count_edge_sel_hi(ctrl_r[i][EDGE_HI_BIT]),
      .count_edge_sel_lo(ctrl_r[i][EDGE_LO_BIT]),
      .count_en(count_en[i])
    );
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_int_fall_div4: assert property (
    (ctrl_r[0] == 6'h01 && cfg_stable[0]) |=> count_en[0] == $past(presc_cnt_r[1:0] == 2'h0))
    else $error("ch0 /4 falling edge enable wrong");
  a_int_rise_div4: assert property (
    (ctrl_r[0] == 6'h09 && cfg_stable[0]) |=> count_en[0] == $past(presc_cnt_r[1:0] == 2'h2))
    else $error("ch0 /4 rising edge enable wrong");
  a_both_edges_div4: assert property (
    (ctrl_r[0][4:0] == 5'h11 || ctrl_r[0][4:0] == 5'h19) && cfg_stable[0]
      |=> count_en[0] == !$past(presc_cnt_r[0]))
    else $error("ch0 both edges enable wrong");
  a_ch0_undiv_run: assert property (
    (reset_n && ctrl_r[0][2:0] == 3'h0) |=> count_en[0])
    else $error("ch0 undivided not every cycle");
  a_ext_pin_rise: assert property (
    (ctrl_r[0] == 6'h04 && cfg_stable[0])
      |=> count_en[0] == $past(pin_sync_r[0] & ~pin_q_r[0]))
    else $error("ch0 pin A rising enable wrong");
  a_ch1_casc_pass: assert property (
    (ctrl_r[1][5] == 1'b0 && ctrl_r[1][2:0] == 3'h7) |=> count_en[1] == $past(channel2_counter_wrap))
    else $error("ch1 cascade enable wrong");
  a_ch2_div1024_fall: assert property (
    (ctrl_r[2] == 6'h07 && cfg_stable[2]) |=> count_en[2] == $past(presc_cnt_r == 10'h000))
    else $error("ch2 /1024 enable wrong");
  a_ch3_undiv_run: assert property (
    (reset_n && ctrl_r[3][2:0] == 3'h0) |=> count_en[3])
    else $error("ch3 undivided not every cycle");
  a_ch4_casc_pass: assert property (
    (ctrl_r[4][5] == 1'b0 && ctrl_r[4][2:0] == 3'h7) |=> count_en[4] == $past(channel5_counter_wrap))
    else $error("ch4 cascade enable wrong");
  a_ch5_pin_d_fall: assert property (
    (ctrl_r[5] == 6'h0f && cfg_stable[5])
      |=> count_en[5] == $past(~pin_sync_r[3] & pin_q_r[3]))
    else $error("ch5 pin D falling enable wrong");
  a_phase_blocks_en: assert property (
    ctrl_r[2][PHASE_BIT] |=> !count_en[2])
    else $error("ch2 counted in phase mode");

  c_ext_count: cover property (ctrl_r[0][2] && count_en[0]);
  c_casc_count: cover property (ctrl_r[4][2:0] == 3'h7 && count_en[4]);
  c_phase_mode: cover property (ctrl_r[5][PHASE_BIT] ##1 !count_en[5]);
  c_apb_error: cover property (pready_r && pslverr_r);

endmodule

// ### rtl/tccs_pkg.sv
// Shared constants and types for the timer count clock select block
package tccs_pkg;

  // Structure
  localparam int NUM_CH = 6;
  localparam int NUM_PINS = 4;
  localparam int ADDR_W = 8;
  localparam int PRESC_W = 10;
  localparam int CTRL_W = 6;

  // Register map (byte addresses)
  localparam logic [ADDR_W-1:0] CTRL0_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h18;
  localparam logic [5:0] STATUS_INDEX = 6'h06;

  // Control register fields
  localparam int PSC_LSB = 0;
  localparam int PSC_MSB = 2;
  localparam int EDGE_LO_BIT = 3;
  localparam int EDGE_HI_BIT = 4;
  localparam int PHASE_BIT = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

  // Channels able to run phase counting (bit per channel)
  localparam logic [NUM_CH-1:0] PHASE_CAPABLE = 6'h36;

  // Divider ratios as log2 of the ratio
  localparam logic [3:0] DIV4_LOG2 = 4'h2;
  localparam logic [3:0] DIV16_LOG2 = 4'h4;
  localparam logic [3:0] DIV64_LOG2 = 4'h6;
  localparam logic [3:0] DIV256_LOG2 = 4'h8;
  localparam logic [3:0] DIV1024_LOG2 = 4'ha;

  // External pin indices
  localparam logic [1:0] PIN_A = 2'h0;
  localparam logic [1:0] PIN_C = 2'h2;
  localparam logic [1:0] PIN_D = 2'h3;

  // Kind of count source chosen for a channel
  typedef enum logic [2:0] {SRC_OFF, SRC_UNDIV, SRC_DIV, SRC_EXT, SRC_CASC} tccs_src_e;

endpackage

// ### rtl/tccs_edge_gate.sv
// Per-channel edge qualifier turning a selected source into a count enable
`timescale 1ns/10ps
module tccs_edge_gate
  import tccs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Selected source
  input wire tccs_pkg::tccs_src_e src_kind,
  input wire logic src_level,
  input wire logic casc_pulse,
  // Edge field
  input wire logic count_edge_sel_hi,
  input wire logic count_edge_sel_lo,
  // Result
  output logic count_en
);
  import tccs_pkg::*;

  logic level_prev_r;
  logic count_en_r;
  logic count_en_nxt;
  logic rise;
  logic fall;

  // Previous level of whatever source is selected
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      level_prev_r <= 1'b0;
    else
      level_prev_r <= src_level;
  end

  // Edge choice; internal and external sense are opposite for the same code
  always_comb
  begin
    rise = src_level & ~level_prev_r;
    fall = ~src_level & level_prev_r;
    case (src_kind)
      SRC_UNDIV: count_en_nxt = 1'b1;
      SRC_DIV:
      begin
        if (count_edge_sel_hi)
          count_en_nxt = rise | fall;
        else if (count_edge_sel_lo)
          count_en_nxt = rise;
        else
          count_en_nxt = fall;
      end
      SRC_EXT:
      begin
        if (count_edge_sel_hi)
          count_en_nxt = rise | fall;
        else if (count_edge_sel_lo)
          count_en_nxt = fall;
        else
          count_en_nxt = rise;
      end
      SRC_CASC: count_en_nxt = casc_pulse;
      default: count_en_nxt = 1'b0;
    endcase
  end

  // Registered enable, one cycle per qualifying edge
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      count_en_r <= 1'b0;
    else
      count_en_r <= count_en_nxt;
  end

  assign count_en = count_en_r;

endmodule

// ### tb/tb_top.sv
// Self-checking bench for the count clock select block
`timescale 1ns/10ps
module tb_top;
  import tccs_pkg::*;
  typedef struct {int ch; logic [5:0] ctrl; int exp;} tccs_row_s;
  localparam int WIN = 1024;
  logic clk, reset_n, psel, penable, pwrite, pslverr, pready;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pa, pb, pc, pd, wrap2, wrap5, er, pin_run, man_a;
  logic [5:0] count_en;
  logic [7:0] cyc;
  int n_fail, n_checks, cnt;
  // Ctrl code to expected pulses in one window; pins and wraps run free
  tccs_row_s rows[$] = '{
    '{0,6'h00,1024}, '{0,6'h01,256}, '{0,6'h02,64}, '{0,6'h04,128}, '{0,6'h05,64},
    '{0,6'h06,32}, '{0,6'h07,16}, '{0,6'h0c,128}, '{0,6'h11,512}, '{0,6'h14,256},
    '{0,6'h18,1024}, '{1,6'h06,4}, '{1,6'h07,64}, '{1,6'h1f,64}, '{1,6'h20,0},
    '{1,6'h04,128}, '{1,6'h05,64}, '{2,6'h01,256}, '{2,6'h07,1}, '{2,6'h04,128},
    '{2,6'h05,64}, '{2,6'h06,32}, '{2,6'h21,0}, '{3,6'h00,1024}, '{3,6'h04,128},
    '{3,6'h01,256}, '{3,6'h02,64}, '{3,6'h03,16}, '{3,6'h05,4}, '{3,6'h06,1},
    '{3,6'h07,1}, '{4,6'h03,16}, '{4,6'h06,1}, '{4,6'h05,32}, '{4,6'h07,64},
    '{4,6'h02,64}, '{5,6'h04,128}, '{5,6'h05,32}, '{5,6'h07,16}, '{5,6'h00,1024},
    '{5,6'h01,256}, '{5,6'h06,1}, '{5,6'h20,0}, '{0,6'h09,256}, '{0,6'h03,16},
    '{1,6'h01,256}, '{1,6'h02,64}, '{1,6'h03,16}, '{2,6'h00,1024}, '{2,6'h02,64},
    '{2,6'h03,16}, '{3,6'h24,128}, '{4,6'h00,1024}, '{4,6'h01,256}, '{4,6'h04,128},
    '{4,6'h27,0}, '{5,6'h02,64}, '{5,6'h03,16}, '{5,6'h0f,16}};

  tccs_top dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_count_pin_a(pa), .ext_count_pin_b(pb), .ext_count_pin_c(pc),
    .ext_count_pin_d(pd), .channel2_counter_wrap(wrap2), .channel5_counter_wrap(wrap5),
    .count_en(count_en));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Free-running pin waves (periods 8/16/32/64) and a wrap pulse every 16
  always @(posedge clk)
  begin
    cyc <= cyc + 8'h01;
    pa <= pin_run ? cyc[2] : man_a;
    pb <= pin_run & cyc[3];
    pc <= pin_run & cyc[4];
    pd <= pin_run & cyc[5];
    wrap2 <= pin_run && (cyc[3:0] == 4'hf);
    wrap5 <= pin_run && (cyc[3:0] == 4'hf);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; answer is taken at the rising edge that sees pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Pre-edge values are seen here, since the slave updates by non-blocking
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      chk(32'h0, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Pulses in a window where every masked enable is high together
  task automatic measure(input logic [5:0] mask, input int len);
    cnt = 0;
    repeat (len)
    begin
      @(negedge clk);
      if ((count_en & mask) === mask)
        cnt++;
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #1_700_000;
    n_fail++;
    final_report();
  end

  initial
  begin
    {reset_n, psel, penable, pwrite, pin_run, man_a} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    cyc = 8'h00;
    n_fail = 0;
    n_checks = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    // Reset values, status after reset shows all channels undivided
    for (int i = 0; i < NUM_CH; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk(rd, 32'h3f);
    // Unmapped word errors, status write ignored quietly
    apb(1'b1, 8'h1c, 32'h3f);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 8'h1c, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(1'b1, STATUS_OFFSET, 32'h0);
    chk({31'h0, er}, 32'h0);
    $display("register test done");
    // Table of sources; also checks readback masking of the phase bit
    pin_run <= 1'b1;
    foreach (rows[r])
    begin
      apb(1'b1, 8'(4 * rows[r].ch), {26'h0, rows[r].ctrl});
      apb(1'b0, 8'(4 * rows[r].ch), 32'h0);
      chk(rd, (rows[r].ch % 3 == 0) ? {27'h0, rows[r].ctrl[4:0]} : {26'h0, rows[r].ctrl});
      repeat (8) @(posedge clk);
      measure(6'(1 << rows[r].ch), WIN);
      chk(cnt, rows[r].exp);
      $display("row %0d done", r);
    end
    // Falling /4 and rising /4 never coincide; two falling always do
    apb(1'b1, 8'h00, 32'h01);
    apb(1'b1, 8'h04, 32'h01);
    repeat (8) @(posedge clk);
    measure(6'h03, WIN);
    chk(cnt, 256);
    apb(1'b1, 8'h04, 32'h09);
    repeat (8) @(posedge clk);
    measure(6'h03, WIN);
    chk(cnt, 0);
    $display("internal polarity test done");
    // Single pin edges: one pulse each, on the chosen edge only
    pin_run <= 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      apb(1'b1, 8'h00, k ? 32'h0c : 32'h04);
      repeat (8) @(posedge clk);
      man_a <= 1'b1;
      measure(6'h01, 8);
      chk(cnt, k ? 0 : 1);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      chk(rd[9:6], 4'h1);
      man_a <= 1'b0;
      measure(6'h01, 8);
      chk(cnt, k ? 1 : 0);
    end
    $display("pin edge test done");
    // Reset in mid-run clears the channel 2 control register
    apb(1'b1, 8'h08, 32'h27);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    $display("second reset test done");
    final_report();
  end
endmodule
